/* verilog/startup_host.sv */
`timescale 1ns/1ps
module startup_host (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Converter setting port
  output logic             dev_req_o,
  output logic      [3:0]  dev_sel_o,
  output logic      [7:0]  dev_data_o,
  input  wire logic        dev_ack_i,
  // Clocking, SYSREF and link
  input  wire logic        clk_stable_i,
  output logic             sysref_run_o,
  input  wire logic        sysref_ok_i,
  input  wire logic        sync_n_i,
  // Supplies
  input  wire logic        analog_high_supply_pg_i,
  output logic             core_low_supplies_en_o
);

  startup_pkg::state_t state_reg;
  startup_pkg::state_t state_next;
  logic [3:0]  step_reg;
  logic [31:0] cfg_reg;
  logic        go_reg;
  logic        pwr_req_reg;
  logic        link_en_reg;
  logic        cal_en_reg;
  logic        trig_reg;

  // Setting and value written at each step of the sequence.
  function automatic logic [11:0] step_word(input logic [3:0] s, input logic [31:0] c);
    logic [4:0] k;
    k = c[startup_pkg::CFG_K_LSB +: 5];
    case (s)
      4'h0:    step_word = {startup_pkg::SEL_LINK_EN, 8'h00};
      4'h1:    step_word = {startup_pkg::SEL_CAL_EN, 8'h00};
      4'h2:    step_word = {startup_pkg::SEL_MODE, 3'h0, c[startup_pkg::CFG_MODE_LSB +: 5]};
      4'h3:    step_word = {startup_pkg::SEL_KM1, 3'h0, 5'(k - 5'h01)};
      4'h4:    step_word = {startup_pkg::SEL_SYNC, 7'h00, c[startup_pkg::CFG_SYNC]};
      4'h5:    step_word = {startup_pkg::SEL_CALCFG, 6'h00, c[startup_pkg::CFG_OFS],
                            c[startup_pkg::CFG_BG]};
      4'h6:    step_word = {startup_pkg::SEL_CAL_EN, 8'h01};
      4'h7:    step_word = {startup_pkg::SEL_OVR, 7'h00, c[startup_pkg::CFG_OVR]};
      4'h8:    step_word = {startup_pkg::SEL_LINK_EN, 8'h01};
      4'h9:    step_word = {startup_pkg::SEL_TRIG, 8'h00};
      default: step_word = {startup_pkg::SEL_TRIG, 8'h01};
    endcase
  endfunction

  // Bus decode.
  wire        bus_req  = cyc_i & stb_i & ~ack_o;
  wire        bus_wr   = bus_req & we_i;
  wire        hit_ctrl = adr_i == startup_pkg::ADDR_CTRL;
  wire        hit_cfg  = adr_i == startup_pkg::ADDR_CFG;
  wire        hit_stat = adr_i == startup_pkg::ADDR_STAT;
  wire        ctrl_wr  = bus_wr & hit_ctrl & sel_i[0];
  wire [31:0] stat_word = {20'h00000, step_reg, 1'b0, trig_reg, cal_en_reg, link_en_reg,
                           analog_high_supply_pg_i, core_low_supplies_en_o,
                           state_reg == startup_pkg::S_DONE,
                           state_reg != startup_pkg::S_IDLE &&
                           state_reg != startup_pkg::S_DONE};
  wire [31:0] rd_word = hit_ctrl ? {30'h0, pwr_req_reg, 1'b0} :
                        hit_cfg  ? cfg_reg :
                        hit_stat ? stat_word : 32'h0000_0000;

  // Sequencer decode.
  wire [11:0] word_now  = step_word(step_reg, cfg_reg);
  wire        acked     = dev_req_o & dev_ack_i;
  wire        power_ok  = core_low_supplies_en_o & analog_high_supply_pg_i;
  wire        start_ok  = go_reg & clk_stable_i & power_ok;
  wire        step_last = step_reg == startup_pkg::STEP_LAST;
  // A start pulse that lands mid-sequence is refused; letting it through would
  // rewind the step counter while the state machine carries on.
  wire        start_take = start_ok &&
                           (state_reg == startup_pkg::S_IDLE || state_reg == startup_pkg::S_DONE);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      dat_o <= bus_req ? rd_word : 32'h0000_0000;
    end
  end

  // Unmapped writes are acknowledged and dropped.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      go_reg      <= 1'b0;
      pwr_req_reg <= 1'b0;
      cfg_reg     <= startup_pkg::CFG_RST;
    end else begin
      go_reg <= ctrl_wr & dat_i[startup_pkg::CTRL_GO];
      if (ctrl_wr) begin
        pwr_req_reg <= dat_i[startup_pkg::CTRL_PWR];
      end
      for (int b = 0; b < 4; b++) begin
        if (bus_wr && hit_cfg && sel_i[b]) begin
          cfg_reg[b*8 +: 8] <= dat_i[b*8 +: 8];
        end
      end
    end
  end

  // The enable follows the power-good level while the CTRL_PWR request bit is set, with one flop of delay, so a
  // failing analog supply removes the core supplies on the next edge.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_low_supplies_en_o <= 1'b0;
    end else begin
      core_low_supplies_en_o <= pwr_req_reg & analog_high_supply_pg_i;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      startup_pkg::S_IDLE: begin
        if (start_ok) begin
          state_next = startup_pkg::S_REQ;
        end
      end
      startup_pkg::S_REQ: begin
        state_next = startup_pkg::S_WAIT;
      end
      startup_pkg::S_WAIT: begin
        if (acked) begin
          if (step_reg == startup_pkg::STEP_PRE_SYSREF) begin
            state_next = startup_pkg::S_SYSREF;
          end else if (step_reg == startup_pkg::STEP_LINK_ON) begin
            state_next = startup_pkg::S_SYNC;
          end else if (step_last) begin
            state_next = startup_pkg::S_DONE;
          end else begin
            state_next = startup_pkg::S_REQ;
          end
        end
      end
      startup_pkg::S_SYSREF: begin
        if (sysref_ok_i) begin
          state_next = startup_pkg::S_REQ;
        end
      end
      startup_pkg::S_SYNC: begin
        if (sync_n_i) begin
          state_next = startup_pkg::S_REQ;
        end
      end
      startup_pkg::S_DONE: begin
        if (start_ok) begin
          state_next = startup_pkg::S_REQ;
        end
      end
      default: state_next = startup_pkg::S_IDLE;
    endcase
    // Losing the supplies abandons the sequence; it restarts from step zero.
    if (!power_ok) begin
      state_next = startup_pkg::S_IDLE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= startup_pkg::S_IDLE;
      step_reg  <= 4'h0;
    end else begin
      state_reg <= state_next;
      if (state_next == startup_pkg::S_IDLE || start_take) begin
        step_reg <= 4'h0;
      end else if (acked) begin
        step_reg <= step_reg + 4'h1;
      end
    end
  end

  // A request holds until acknowledged or the supplies are lost, and drops for at least one cycle.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dev_req_o  <= 1'b0;
      dev_sel_o  <= 4'h0;
      dev_data_o <= 8'h00;
    end else begin
      // No request is raised in the cycle the supplies are lost.
      if (state_reg == startup_pkg::S_REQ && power_ok) begin
        dev_req_o  <= 1'b1;
        dev_sel_o  <= word_now[11:8];
        dev_data_o <= word_now[7:0];
      end else if (acked || state_next == startup_pkg::S_IDLE) begin
        dev_req_o  <= 1'b0;
      end
    end
  end

  // SYSREF is requested as a continuous stream ahead of the link restart.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sysref_run_o <= 1'b0;
    end else if (state_next == startup_pkg::S_IDLE) begin
      sysref_run_o <= 1'b0;
    end else if (state_next == startup_pkg::S_SYSREF) begin
      sysref_run_o <= 1'b1;
    end
  end

  // Shadows of what the converter has accepted, shown in the status word.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_en_reg <= 1'b0;
      cal_en_reg  <= 1'b0;
      trig_reg    <= 1'b0;
    end else if (acked) begin
      if (dev_sel_o == startup_pkg::SEL_LINK_EN) begin
        link_en_reg <= dev_data_o[0];
      end
      if (dev_sel_o == startup_pkg::SEL_CAL_EN) begin
        cal_en_reg <= dev_data_o[0];
      end
      if (dev_sel_o == startup_pkg::SEL_TRIG) begin
        trig_reg <= dev_data_o[0];
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Previous request level, kept in a flop so the edge test stays plain logic.
  logic req_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_q <= 1'b0;
    end else begin
      req_q <= dev_req_o;
    end
  end

  wire req_rise = dev_req_o & ~req_q;

  property p_clk_before_cfg;
    state_reg == startup_pkg::S_IDLE && state_next == startup_pkg::S_REQ |-> clk_stable_i;
  endproperty
  a_clk_before_cfg: assert property (p_clk_before_cfg)
    else $error("Configuration began without a stable clock.");

  property p_mode_after_stop;
    req_rise && dev_sel_o == startup_pkg::SEL_MODE |-> !link_en_reg && !cal_en_reg;
  endproperty
  a_mode_after_stop: assert property (p_mode_after_stop)
    else $error("Link mode written while an engine ran.");

  property p_stop_first;
    req_rise && dev_sel_o == startup_pkg::SEL_CAL_EN && dev_data_o == 8'h00
      |-> $past(link_en_reg) == 1'b0 && step_reg == 4'h1;
  endproperty
  a_stop_first: assert property (p_stop_first)
    else $error("Calibration stop not preceded by link stop.");

  property p_km1;
    req_rise && dev_sel_o == startup_pkg::SEL_KM1
      |-> dev_data_o == {3'h0, 5'(cfg_reg[startup_pkg::CFG_K_LSB +: 5] - 5'h01)};
  endproperty
  a_km1: assert property (p_km1)
    else $error("Multiframe field is not frames minus one.");

  property p_cal_on_after_cfg;
    acked && dev_sel_o == startup_pkg::SEL_CALCFG
      |-> ##[1:3] dev_req_o && dev_sel_o == startup_pkg::SEL_CAL_EN && dev_data_o == 8'h01;
  endproperty
  a_cal_on_after_cfg: assert property (p_cal_on_after_cfg)
    else $error("Calibration enable did not follow its setup.");

  property p_link_on_sysref;
    req_rise && dev_sel_o == startup_pkg::SEL_LINK_EN && dev_data_o == 8'h01
      |-> sysref_run_o && $past(sysref_ok_i, 2);
  endproperty
  a_link_on_sysref: assert property (p_link_on_sysref)
    else $error("Link enabled before SYSREF was confirmed.");

  property p_trig_low_high;
    req_rise && dev_sel_o == startup_pkg::SEL_TRIG && dev_data_o == 8'h01
      |-> !trig_reg && link_en_reg && $past(trig_reg) == 1'b0;
  endproperty
  a_trig_low_high: assert property (p_trig_low_high)
    else $error("Trigger high without a prior low write.");

  property p_core_on;
    $rose(core_low_supplies_en_o) |-> $past(analog_high_supply_pg_i);
  endproperty
  a_core_on: assert property (p_core_on)
    else $error("Core supplies enabled before analog good.");

  property p_core_off;
    !analog_high_supply_pg_i |=> !core_low_supplies_en_o;
  endproperty
  a_core_off: assert property (p_core_off)
    else $error("Core supplies kept after analog failure.");

  property p_hold_req;
    dev_req_o && !dev_ack_i && power_ok
      |=> dev_req_o && $stable(dev_sel_o) && $stable(dev_data_o);
  endproperty
  a_hold_req: assert property (p_hold_req)
    else $error("Setting request changed before its answer.");

  property p_gap;
    acked |=> !dev_req_o;
  endproperty
  a_gap: assert property (p_gap)
    else $error("Request not dropped after its answer.");

  property p_busy_start;
    go_reg && power_ok && !acked && state_reg != startup_pkg::S_IDLE &&
      state_reg != startup_pkg::S_DONE |=> $stable(step_reg);
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("Start pulse disturbed a running sequence.");

  property p_no_power_req;
    !power_ok |=> !dev_req_o;
  endproperty
  a_no_power_req: assert property (p_no_power_req)
    else $error("Setting request raised without supplies.");

  // Main scenarios: a full run, a slow SYSREF, an abort and a restart.

  c_done: cover property (state_reg == startup_pkg::S_DONE);
  c_sysref_wait: cover property ((state_reg == startup_pkg::S_SYSREF && !sysref_ok_i) [*3]);
  c_restart: cover property (state_reg == startup_pkg::S_DONE ##1 state_reg == startup_pkg::S_REQ);
  c_abort: cover property (state_reg == startup_pkg::S_WAIT ##1 state_reg == startup_pkg::S_IDLE);

endmodule

/* verilog/startup_pkg.sv */
package startup_pkg;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CFG  = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;

  localparam int CTRL_GO  = 0;
  localparam int CTRL_PWR = 1;

  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_K_LSB    = 8;
  localparam int CFG_SYNC     = 16;
  localparam int CFG_BG       = 17;
  localparam int CFG_OFS      = 18;
  localparam int CFG_OVR      = 19;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;

  localparam logic [3:0] SEL_LINK_EN = 4'h0;
  localparam logic [3:0] SEL_CAL_EN  = 4'h1;
  localparam logic [3:0] SEL_MODE    = 4'h2;
  localparam logic [3:0] SEL_KM1     = 4'h3;
  localparam logic [3:0] SEL_SYNC    = 4'h4;
  localparam logic [3:0] SEL_CALCFG  = 4'h5;
  localparam logic [3:0] SEL_OVR     = 4'h6;
  localparam logic [3:0] SEL_TRIG    = 4'h7;

  localparam logic [3:0] STEP_PRE_SYSREF = 4'h7;
  localparam logic [3:0] STEP_LINK_ON    = 4'h8;
  localparam logic [3:0] STEP_LAST       = 4'ha;

  typedef enum logic [2:0] {
    S_IDLE,
    S_REQ,
    S_WAIT,
    S_SYSREF,
    S_SYNC,
    S_DONE
  } state_t;

endpackage

/* dv/conv_model.sv */
`timescale 1ns/1ps
module conv_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Setting port
  input  wire logic       req_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [7:0] data_i,
  output logic            ack_o,
  input  wire logic [3:0] delay_i,
  // SYSREF and link
  input  wire logic       sysref_run_i,
  output logic            sysref_ok_o,
  output logic            sync_n_o
);
  logic [7:0] set_reg [8];
  logic [3:0] wait_reg;
  logic [3:0] sel_log [16];
  logic [7:0] dat_log [16];
  int         n;
  int         bad;
  wire        stopped = !set_reg[0][0] && !set_reg[1][0];
  wire        cfg_w   = sel_i inside {[4'h2:4'h5]};
  // Any write out of place is counted, so the bench sees it as one number.
  wire        wrong   = (cfg_w && !stopped) ||
                        (sel_i == 4'h0 && data_i[0] && !sysref_ok_o) ||
                        (sel_i == 4'h7 && (!sync_n_o || (data_i[0] && set_reg[7][0])));

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o       <= 1'b0;
      wait_reg    <= 4'h0;
      n           <= 0;
      bad         <= 0;
      sysref_ok_o <= 1'b0;
      sync_n_o    <= 1'b0;
      for (int i = 0; i < 8; i++) set_reg[i] <= 8'h00;
    end else begin
      // Capture is reported a cycle late, so a host that does not wait is caught.
      sysref_ok_o <= sysref_run_i;
      sync_n_o    <= set_reg[0][0];
      if (ack_o && !req_i) bad <= bad + 1;
      if (req_i && ack_o) begin
        ack_o               <= 1'b0;
        wait_reg            <= 4'h0;
        set_reg[sel_i[2:0]] <= data_i;
        sel_log[n[3:0]]     <= sel_i;
        dat_log[n[3:0]]     <= data_i;
        n                   <= n + 1;
        if (wrong) bad <= bad + 1;
      end else if (req_i && wait_reg >= delay_i) begin
        ack_o <= 1'b1;
      end else if (req_i) begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [3:0]  adr_i = 4'h0;
  logic [3:0]  sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        dev_req_o;
  logic [3:0]  dev_sel_o;
  logic [7:0]  dev_data_o;
  logic        dev_ack_i;
  logic        clk_stable_i = 1'b1;
  logic        sysref_run_o;
  logic        sysref_ok_i;
  logic        sync_n_i;
  logic        analog_high_supply_pg_i = 1'b0;
  logic        core_low_supplies_en_o;
  logic [3:0]  delay = 4'h0;
  logic [31:0] q;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #50 clk_i = ~clk_i;

  startup_host DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .dev_req_o(dev_req_o), .dev_sel_o(dev_sel_o), .dev_data_o(dev_data_o),
    .dev_ack_i(dev_ack_i), .clk_stable_i(clk_stable_i), .sysref_run_o(sysref_run_o),
    .sysref_ok_i(sysref_ok_i), .sync_n_i(sync_n_i),
    .analog_high_supply_pg_i(analog_high_supply_pg_i),
    .core_low_supplies_en_o(core_low_supplies_en_o));

  conv_model partner (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(dev_req_o),
    .sel_i(dev_sel_o), .data_i(dev_data_o), .ack_o(dev_ack_i), .delay_i(delay),
    .sysref_run_i(sysref_run_o), .sysref_ok_o(sysref_ok_i), .sync_n_o(sync_n_i));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
  endtask

  task automatic wb(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= wr;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    if (k >= 50) fail_count++;
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(q & m, e);
  endtask

  task automatic launch();
    analog_high_supply_pg_i <= 1'b1;
    wb(1'b1, startup_pkg::ADDR_CTRL, 32'h2);
    wb(1'b1, startup_pkg::ADDR_CTRL, 32'h3);
  endtask

  task automatic t_regs();
    do_reset();
    rd(startup_pkg::ADDR_STAT, 32'hffff_ffff, 32'h0);
    rd(startup_pkg::ADDR_CFG, 32'hffff_ffff, startup_pkg::CFG_RST);
    wb(1'b1, startup_pkg::ADDR_STAT, 32'hffff_ffff);
    rd(startup_pkg::ADDR_STAT, 32'hffff_ffff, 32'h0);
    rd(4'hc, 32'hffff_ffff, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_power();
    wb(1'b1, startup_pkg::ADDR_CTRL, 32'h2);
    repeat (3) @(posedge clk_i);
    check({31'h0, core_low_supplies_en_o}, 32'h0);
    analog_high_supply_pg_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({31'h0, core_low_supplies_en_o}, 32'h1);
    rd(startup_pkg::ADDR_CTRL, 32'h3, 32'h2);
    analog_high_supply_pg_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({31'h0, core_low_supplies_en_o}, 32'h0);
    $display("test power done");
  endtask

  task automatic t_noclk();
    clk_stable_i <= 1'b0;
    launch();
    repeat (8) @(posedge clk_i);
    check({31'h0, dev_req_o}, 32'h0);
    rd(startup_pkg::ADDR_STAT, 32'h3, 32'h0);
    check(32'(partner.n), 32'h0);
    clk_stable_i <= 1'b1;
    $display("test clock wait done");
  endtask

  task automatic t_full(input logic [3:0] dly, input logic [4:0] mode, input logic [4:0] k,
                        input logic syn, input logic bg, input logic ofs, input logic ovr);
    logic [3:0]  s [11];
    logic [7:0]  e [11];
    logic [31:0] cfg;
    int          w;
    s   = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h1, 4'h6, 4'h0, 4'h7, 4'h7};
    e   = '{8'h00, 8'h00, {3'h0, mode}, {3'h0, k} - 8'h01, {7'h0, syn}, {6'h0, ofs, bg},
            8'h01, {7'h0, ovr}, 8'h01, 8'h00, 8'h01};
    cfg = {12'h0, ovr, ofs, bg, syn, 3'h0, k, 3'h0, mode};
    w   = 0;
    do_reset();
    delay <= dly;
    wb(1'b1, startup_pkg::ADDR_CFG, cfg);
    rd(startup_pkg::ADDR_CFG, 32'hffff_ffff, cfg);
    launch();
    do begin
      wb(1'b0, startup_pkg::ADDR_STAT, 32'h0);
      w++;
    end while (q[1] !== 1'b1 && w < 300);
    if (w >= 300) fail_count++;
    check(32'(partner.n), 32'h0000_000b);
    for (int i = 0; i < 11; i++) begin
      check({28'h0, partner.sel_log[i]}, {28'h0, s[i]});
      check({24'h0, partner.dat_log[i]}, {24'h0, e[i]});
    end
    check(32'(partner.bad), 32'h0);
    rd(startup_pkg::ADDR_STAT, 32'hff, 32'h7e);
    check({31'h0, sysref_run_o}, 32'h1);
    $display("test sequence done");
  endtask

  task automatic t_restart();
    int w;
    w = 0;
    wb(1'b1, startup_pkg::ADDR_CTRL, 32'h3);
    repeat (20) @(posedge clk_i);
    // This start lands mid-sequence and must be refused.
    wb(1'b1, startup_pkg::ADDR_CTRL, 32'h3);
    do begin
      wb(1'b0, startup_pkg::ADDR_STAT, 32'h0);
      w++;
    end while (q[1] !== 1'b1 && w < 300);
    if (w >= 300) fail_count++;
    check(32'(partner.n), 32'h0000_0016);
    check(32'(partner.bad), 32'h0);
    rd(startup_pkg::ADDR_STAT, 32'hff, 32'h7e);
    $display("test restart done");
  endtask

  task automatic t_abort();
    do_reset();
    delay <= 4'hf;
    launch();
    repeat (20) @(posedge clk_i);
    analog_high_supply_pg_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({31'h0, dev_req_o}, 32'h0);
    check({31'h0, core_low_supplies_en_o}, 32'h0);
    rd(startup_pkg::ADDR_STAT, 32'h3, 32'h0);
    $display("test power loss done");
  endtask

  task automatic t_midreset();
    delay <= 4'h2;
    launch();
    repeat (15) @(posedge clk_i);
    // The full check after this reset proves the order starts again from step 0.
    t_full(4'h2, 5'h03, 5'h08, 1'b1, 1'b1, 1'b1, 1'b1);
    $display("test reset in sequence done");
  endtask

  initial begin
    t_regs();
    t_power();
    t_noclk();
    t_full(4'h0, 5'h1f, 5'h01, 1'b1, 1'b1, 1'b0, 1'b1);
    t_restart();
    t_full(4'h7, 5'h00, 5'h1f, 1'b0, 1'b0, 1'b1, 1'b0);
    t_abort();
    t_midreset();
    complete_run();
  end
endmodule
